//--- rtl/pmt_icp.sv
// Serial in-circuit programming engine.
// Assumes data and clock levels already synchronised to clock.
`default_nettype none

module pmt_icp #(
  parameter int unsigned AW = 11,
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic sdata,
  input wire logic sclk,
  output logic sdata_out,
  output logic sdata_oe,
  output logic [AW-1:0] mem_addr,
  output logic mem_wr_en,
  output logic [WIDTH-1:0] mem_wr_data,
  input wire logic [WIDTH-1:0] mem_rdata,
  output logic ee_wr_en,
  output logic ee_rd_en,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  input wire logic [7:0] ee_rdata
);

  logic sclk_prev;
  logic [5:0] bit_cnt;
  logic [15:0] hdr;
  logic [15:0] shreg;
  logic [1:0] wait_cnt;
  logic loaded;

  wire rise = sclk && !sclk_prev;
  wire [1:0] cmd = hdr[15:14];
  wire is_read = cmd[0];
  wire is_ee = cmd[1];
  wire in_data = bit_cnt >= 6'(pmt_pkg::ICP_HDR_BITS);
  wire load_now = in_data && !loaded && wait_cnt == pmt_pkg::ICP_LOAD_WAIT;
  wire last_bit = rise && bit_cnt == 6'(pmt_pkg::ICP_FRAME_BITS - 1);
  wire [15:0] read_word = is_ee ? {8'h00, ee_rdata} : 16'(mem_rdata);

  assign mem_addr = hdr[AW-1:0];
  assign ee_addr = hdr[7:0];
  assign ee_wdata = shreg[7:0];
  assign mem_wr_data = shreg[WIDTH-1:0];

  // ----------------------------------------------------------------
  // Frame: 2-bit command, 14-bit address, 16 data bits, MSB first
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
      bit_cnt <= '0;
      hdr <= '0;
      shreg <= '0;
      wait_cnt <= '0;
      loaded <= 1'b0;
      mem_wr_en <= 1'b0;
      ee_wr_en <= 1'b0;
      ee_rd_en <= 1'b0;
      sdata_out <= 1'b0;
      sdata_oe <= 1'b0;
    end else if (!enable) begin
      sclk_prev <= 1'b0;
      bit_cnt <= '0;
      wait_cnt <= '0;
      loaded <= 1'b0;
      mem_wr_en <= 1'b0;
      ee_wr_en <= 1'b0;
      ee_rd_en <= 1'b0;
      sdata_oe <= 1'b0;
    end else begin
      sclk_prev <= sclk;
      mem_wr_en <= last_bit && !is_read && !is_ee;
      ee_wr_en <= last_bit && !is_read && is_ee;
      ee_rd_en <= in_data && !loaded && wait_cnt == 2'h0 && is_read && is_ee;
      if (in_data && !loaded && wait_cnt != pmt_pkg::ICP_LOAD_WAIT) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
      if (load_now) begin
        loaded <= 1'b1;
        if (is_read) begin
          shreg <= read_word;
        end
      end else if (rise && in_data) begin
        shreg <= {shreg[14:0], is_read ? 1'b0 : sdata};
      end
      if (rise && !in_data) begin
        hdr <= {hdr[14:0], sdata};
      end
      if (last_bit) begin
        bit_cnt <= '0;
        loaded <= 1'b0;
        wait_cnt <= '0;
      end else if (rise) begin
        bit_cnt <= bit_cnt + 6'h1;
      end
      sdata_out <= shreg[15];
      sdata_oe <= is_read && in_data && loaded && !last_bit;
    end
  end

endmodule : pmt_icp

`default_nettype wire

//--- rtl/pmt_mem.sv
// Single-port program word store with registered read data.
// Assumes the caller muxes one address per clock.
`default_nettype none

module pmt_mem #(
  parameter int unsigned DEPTH = 2048,
  parameter int unsigned WIDTH = 16,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] addr,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      store[addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= store[addr];
    end
  end

endmodule : pmt_mem

`default_nettype wire

//--- rtl/pmt_pkg.sv
// Constants and types for the program memory and table read block.
// Assumes one instruction cycle per clock of the core's instruction clock.
//
// Function
// - Program store holds 16-bit words, 1024 or 2048 deep.
// - Fetch uses program counter; table data uses separate table pointer.
// - After any reset the first fetch is at word address zero.
// - Full table address joins low and high pointer registers.
// - Table read writes low byte to the operand's data register.
// - Table read loads high byte into the high-byte latch.
// - High-byte bits with no program-word bit read as zero.
// - Current-page read offsets pointer from executing instruction's page.
// - A page is 256 words; page reads replace low eight bits.
// - Every table instruction completes in two instruction cycles.
// - High-byte latch is read only; nothing but table reads load it.
// - Reset pin held low suspends normal operation during programming.
// - Programming uses data pin bidirectional and clock pin, programmer led.
// - Serial access writes and reads program store and data EEPROM.
`default_nettype none

package pmt_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned DEPTH_SMALL = 1024;
  localparam int unsigned DEPTH_LARGE = 2048;
  localparam int unsigned PAGE_BITS = 8;
  localparam int unsigned TABLE_CYCLES = 2;

  // ----------------------------------------------------------------
  // Reset values and pin bit positions
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h1;
  localparam int unsigned PIN_RST = 0;
  localparam int unsigned PIN_DAT = 1;
  localparam int unsigned PIN_CLK = 2;

  // ----------------------------------------------------------------
  // Serial programming frame
  // ----------------------------------------------------------------
  localparam int unsigned ICP_HDR_BITS = 16;
  localparam int unsigned ICP_FRAME_BITS = 32;
  localparam logic [1:0] ICP_LOAD_WAIT = 2'h2;

  typedef enum logic [1:0] {
    ICP_WR_PROG = 2'b00,
    ICP_RD_PROG = 2'b01,
    ICP_WR_EE = 2'b10,
    ICP_RD_EE = 2'b11
  } pmt_icp_cmd_e;

  typedef enum logic [1:0] {
    TBL_FULL = 2'b00,
    TBL_CUR = 2'b01,
    TBL_LAST = 2'b10
  } pmt_tbl_kind_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_TBL = 2'b01,
    ST_PROG = 2'b10
  } pmt_state_e;

endpackage : pmt_pkg

`default_nettype wire

//--- rtl/pmt_top.sv
// Program store: instruction fetch, table reads and serial programming.
// Assumes the core holds table pointers and stalls while tbl_busy is high.
`default_nettype none

module pmt_top #(
  parameter int unsigned DEPTH = pmt_pkg::DEPTH_LARGE,
  parameter int unsigned WORD_BITS = pmt_pkg::WORD_BITS,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic external_reset_pin,
  input wire logic icp_data_pin_in,
  output logic icp_data_pin_out,
  output logic icp_data_pin_oe,
  input wire logic icp_clock_pin,
  output logic core_run,
  input wire logic pc_load,
  input wire logic [AW-1:0] pc_load_addr,
  output logic [AW-1:0] fetch_addr,
  output logic [WORD_BITS-1:0] fetch_word,
  output logic fetch_valid,
  input wire logic tbl_req,
  input wire logic [1:0] tbl_kind,
  input wire logic [7:0] tbl_dest,
  input wire logic [7:0] tbl_ptr_low,
  input wire logic [7:0] tbl_ptr_high,
  output logic tbl_busy,
  output logic tbl_wr_en,
  output logic [7:0] tbl_wr_addr,
  output logic [7:0] tbl_wr_data,
  output logic [7:0] table_high_byte_latch,
  output logic ee_wr_en,
  output logic ee_rd_en,
  output logic [7:0] ee_addr,
  output logic [7:0] ee_wdata,
  input wire logic [7:0] ee_rdata
);

  localparam int unsigned PB = pmt_pkg::PAGE_BITS;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] high_byte(input logic [WORD_BITS-1:0] w);
    logic [15:0] ext;
    ext = 16'(w);
    return ext[15:8];
  endfunction : high_byte

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= pmt_pkg::PIN_SYNC_RESET;
      pin_sync <= pmt_pkg::PIN_SYNC_RESET;
    end else begin
      pin_meta <= {icp_clock_pin, icp_data_pin_in, external_reset_pin};
      pin_sync <= pin_meta;
    end
  end

  wire prog_mode = !pin_sync[pmt_pkg::PIN_RST];

  // ----------------------------------------------------------------
  // Address selection
  // ----------------------------------------------------------------
  pmt_pkg::pmt_state_e state;
  pmt_pkg::pmt_state_e next_state;
  logic [AW-1:0] pc;
  logic [AW-1:0] icp_addr;
  logic icp_wr_en;
  logic [WORD_BITS-1:0] icp_wr_data;

  wire in_run = state == pmt_pkg::ST_RUN && !prog_mode;
  wire tbl_take = in_run && tbl_req;
  wire [AW-1:0] fetch_next = pc_load ? pc_load_addr : pc;
  wire [15:0] ptr_full = {tbl_ptr_high, tbl_ptr_low};
  wire [AW-1:0] addr_full = ptr_full[AW-1:0];
  wire [AW-1:0] addr_cur = {fetch_addr[AW-1:PB], tbl_ptr_low};
  wire [AW-1:0] addr_last = {{(AW-PB){1'b1}}, tbl_ptr_low};
  wire [AW-1:0] tbl_addr = tbl_kind == pmt_pkg::TBL_CUR ? addr_cur :
                           tbl_kind == pmt_pkg::TBL_LAST ? addr_last :
                           addr_full;
  wire [AW-1:0] mem_addr = prog_mode ? icp_addr :
                           tbl_take ? tbl_addr : fetch_next;
  wire mem_wr_en = prog_mode && icp_wr_en;
  wire tbl_second = state == pmt_pkg::ST_TBL && !prog_mode;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      pmt_pkg::ST_RUN: begin
        if (tbl_take) begin
          next_state = pmt_pkg::ST_TBL;
        end
      end
      pmt_pkg::ST_TBL: begin
        next_state = pmt_pkg::ST_RUN;
      end
      pmt_pkg::ST_PROG: begin
        next_state = pmt_pkg::ST_RUN;
      end
      default: begin
        next_state = pmt_pkg::ST_PROG;
      end
    endcase
    if (prog_mode) begin
      next_state = pmt_pkg::ST_PROG;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= pmt_pkg::ST_PROG;
      pc <= pmt_pkg::RESET_VECTOR[AW-1:0];
      fetch_addr <= '0;
      fetch_valid <= 1'b0;
      core_run <= 1'b0;
    end else begin
      state <= next_state;
      core_run <= next_state != pmt_pkg::ST_PROG;
      fetch_valid <= in_run && !tbl_req;
      if (state != pmt_pkg::ST_RUN) begin
        if (state == pmt_pkg::ST_PROG) begin
          pc <= pmt_pkg::RESET_VECTOR[AW-1:0];
        end
      end else if (!prog_mode && !tbl_req) begin
        pc <= fetch_next + AW'(1);
        fetch_addr <= fetch_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Table read completion
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tbl_busy <= 1'b0;
      tbl_wr_en <= 1'b0;
      tbl_wr_addr <= '0;
      tbl_wr_data <= '0;
      table_high_byte_latch <= '0;
    end else begin
      tbl_busy <= tbl_take;
      tbl_wr_en <= tbl_second;
      if (tbl_take) begin
        tbl_wr_addr <= tbl_dest;
      end
      if (tbl_second) begin
        tbl_wr_data <= fetch_word[7:0];
        table_high_byte_latch <= high_byte(fetch_word);
      end
    end
  end

  // ----------------------------------------------------------------
  // Store and programming engine
  // ----------------------------------------------------------------
  pmt_mem #(
    .DEPTH(DEPTH),
    .WIDTH(WORD_BITS),
    .AW(AW)
  ) u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .addr(mem_addr),
    .wr_en(mem_wr_en),
    .wr_data(icp_wr_data),
    .rd_data(fetch_word)
  );

  pmt_icp #(
    .AW(AW),
    .WIDTH(WORD_BITS)
  ) u_icp (
    .clock(clock),
    .rst_n(rst_n),
    .enable(prog_mode),
    .sdata(pin_sync[pmt_pkg::PIN_DAT]),
    .sclk(pin_sync[pmt_pkg::PIN_CLK]),
    .sdata_out(icp_data_pin_out),
    .sdata_oe(icp_data_pin_oe),
    .mem_addr(icp_addr),
    .mem_wr_en(icp_wr_en),
    .mem_wr_data(icp_wr_data),
    .mem_rdata(fetch_word),
    .ee_wr_en(ee_wr_en),
    .ee_rd_en(ee_rd_en),
    .ee_addr(ee_addr),
    .ee_wdata(ee_wdata),
    .ee_rdata(ee_rdata)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_reset_fetch_zero: assert property (
    (state == pmt_pkg::ST_PROG && !prog_mode) ##1
    (!prog_mode && !pc_load && !tbl_req) |=> fetch_valid && fetch_addr == '0)
    else $error("first fetch after reset not at word zero");
  a_fetch_jump: assert property (
    in_run && !tbl_req && pc_load |=>
    fetch_valid && fetch_addr == $past(pc_load_addr))
    else $error("jump fetch not at loaded address");
  a_fetch_step: assert property (
    fetch_valid && in_run && !tbl_req && !pc_load |=>
    fetch_valid && fetch_addr == $past(fetch_addr) + AW'(1))
    else $error("sequential fetch skipped a word");
  a_prog_pc_zero: assert property (
    state == pmt_pkg::ST_PROG |=> pc == pmt_pkg::RESET_VECTOR[AW-1:0])
    else $error("program counter not cleared while held");
  a_core_resume: assert property (
    !prog_mode |=> core_run)
    else $error("core not released after reset pin high");

  // ----------------------------------------------------------------
  // Table checks
  // ----------------------------------------------------------------
  a_tbl_two_cycle: assert property (
    tbl_take ##1 !prog_mode |-> tbl_busy && !tbl_wr_en ##1
    (tbl_wr_en && !tbl_busy))
    else $error("table read did not finish in two cycles");
  a_tbl_dest_reg: assert property (
    tbl_take ##1 !prog_mode |=> tbl_wr_addr == $past(tbl_dest, 2))
    else $error("table low byte sent to wrong register");
  a_tbl_low_byte: assert property (
    tbl_wr_en |-> tbl_wr_data == $past(fetch_word[7:0]))
    else $error("table low byte wrong");
  a_latch_high_byte: assert property (
    tbl_wr_en |-> table_high_byte_latch == high_byte($past(fetch_word)))
    else $error("high byte latch wrong");
  a_latch_read_only: assert property (
    !tbl_wr_en |-> $stable(table_high_byte_latch))
    else $error("high byte latch changed without table read");
  a_full_pointer: assert property (
    tbl_take && tbl_kind == pmt_pkg::TBL_FULL |->
    mem_addr == ptr_full[AW-1:0])
    else $error("full table address wrong");
  a_cur_page_addr: assert property (
    tbl_take && tbl_kind == pmt_pkg::TBL_CUR |->
    mem_addr[PB-1:0] == tbl_ptr_low &&
    mem_addr[AW-1:PB] == fetch_addr[AW-1:PB])
    else $error("current page table address wrong");
  a_last_page_addr: assert property (
    tbl_take && tbl_kind == pmt_pkg::TBL_LAST |->
    mem_addr[PB-1:0] == tbl_ptr_low && &mem_addr[AW-1:PB])
    else $error("last page table address wrong");
  a_kind_spare_full: assert property (
    tbl_take && tbl_kind == 2'h3 |-> mem_addr == ptr_full[AW-1:0])
    else $error("spare table kind not using full pointer");
  a_tbl_no_fetch: assert property (
    tbl_busy || tbl_wr_en |-> !fetch_valid)
    else $error("fetch issued during table read");
  a_busy_pulse: assert property (
    tbl_busy |=> !tbl_busy)
    else $error("table busy longer than one cycle");
  a_wr_pulse: assert property (
    tbl_wr_en |=> !tbl_wr_en)
    else $error("table write longer than one cycle");

  // ----------------------------------------------------------------
  // Programming checks
  // ----------------------------------------------------------------
  a_prog_suspend: assert property (
    prog_mode |=> !fetch_valid && !core_run && !tbl_wr_en)
    else $error("core not suspended while reset pin low");
  a_pin_release: assert property (
    !prog_mode |=> !icp_data_pin_oe)
    else $error("data pin driven outside programming");
  a_write_in_prog: assert property (
    ee_wr_en || icp_wr_en |-> $past(prog_mode))
    else $error("store write outside programming");
  a_drive_in_prog: assert property (
    icp_data_pin_oe |-> $past(prog_mode))
    else $error("data pin driven before programming");
  a_ee_rd_pulse: assert property (
    ee_rd_en |=> !ee_rd_en)
    else $error("eeprom read strobe longer than one cycle");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_tbl_full: cover property (tbl_take && tbl_kind == pmt_pkg::TBL_FULL);
  c_tbl_cur: cover property (tbl_take && tbl_kind == pmt_pkg::TBL_CUR);
  c_tbl_last: cover property (tbl_take && tbl_kind == pmt_pkg::TBL_LAST);
  c_prog_write: cover property (mem_wr_en);
  c_prog_read: cover property (icp_data_pin_oe);

endmodule : pmt_top

`default_nettype wire

//--- verification/pmt_prog_model.sv
// Serial programmer model driving the in-circuit programming pins.
// Assumes the bench resolves the shared data pin from both drivers.
`default_nettype none

module pmt_prog_model (
  input wire logic clock,
  input wire logic data_pin,
  output logic drive_val,
  output logic sclk,
  output logic reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4;

  initial begin
    drive_val = 1'b0;
    sclk = 1'b0;
    reset_pin_n = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold

  // Reset pin low for the whole session
  task automatic session(input logic on);
    reset_pin_n = ~on;
    hold(on ? 6 : 2);
  endtask : session

  // One serial clock, data set while the clock is low
  task automatic clock_bit(input logic drive, input logic b,
                           output logic seen);
    if (drive) begin
      drive_val = b;
    end
    hold(HALF);
    seen = data_pin;
    sclk = 1'b1;
    hold(HALF);
    sclk = 1'b0;
  endtask : clock_bit

  // Header then data, MSB first; reads invert drive_val and then stop updating it
  task automatic frame(input logic [1:0] cmd, input logic [13:0] addr,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [15:0] hdr;
    logic s;
    hdr = {cmd, addr};
    for (int i = 15; i >= 0; i--) begin
      clock_bit(1'b1, hdr[i], s);
    end
    if (cmd[0]) begin
      drive_val = ~drive_val;
    end
    hold(8);
    for (int i = 15; i >= 0; i--) begin
      clock_bit(~cmd[0], wdata[i], rdata[i]);
    end
    hold(8);
  endtask : frame
endmodule : pmt_prog_model

`default_nettype wire

//--- verification/program_memory_table_read_bench.sv
// Self-checking bench for the program store with table reads.
// Assumes pmt_prog_model plays the programmer; bench plays the core.
`default_nettype none

module program_memory_table_read_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 11;
  localparam int LIMIT = 12000;

  logic clock, rst_n, pc_load, tbl_req;
  logic [AW-1:0] pc_load_addr, fetch_addr;
  logic [1:0] tbl_kind;
  logic [7:0] tbl_dest, tbl_ptr_low, tbl_ptr_high, ee_rdata;
  logic [15:0] fetch_word, rd;
  logic pin_out, pin_oe, prog_val, sclk, res_n, core_run, fetch_valid;
  logic tbl_busy, tbl_wr_en, ee_wr_en, ee_rd_en;
  logic [7:0] tbl_wr_addr, tbl_wr_data, latch, ee_addr, ee_wdata;
  logic [7:0] ee_a = 8'h00;
  logic [7:0] ee_d = 8'h00;
  logic oe_seen = 1'b0;
  logic rd_seen = 1'b0;
  wire logic data_pin;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;

  assign data_pin = pin_oe ? pin_out : prog_val;

  pmt_top #(.DEPTH(2048)) DUT (.clock(clock), .rst_n(rst_n),
    .external_reset_pin(res_n), .icp_data_pin_in(data_pin),
    .icp_data_pin_out(pin_out), .icp_data_pin_oe(pin_oe),
    .icp_clock_pin(sclk), .core_run(core_run), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .fetch_addr(fetch_addr),
    .fetch_word(fetch_word), .fetch_valid(fetch_valid),
    .tbl_req(tbl_req), .tbl_kind(tbl_kind), .tbl_dest(tbl_dest),
    .tbl_ptr_low(tbl_ptr_low), .tbl_ptr_high(tbl_ptr_high),
    .tbl_busy(tbl_busy), .tbl_wr_en(tbl_wr_en),
    .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
    .table_high_byte_latch(latch), .ee_wr_en(ee_wr_en),
    .ee_rd_en(ee_rd_en), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .ee_rdata(ee_rdata));

  pmt_prog_model prog (.clock(clock), .data_pin(data_pin),
    .drive_val(prog_val), .sclk(sclk), .reset_pin_n(res_n));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Monitors and timeout
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (ee_wr_en === 1'b1) begin
      ee_a <= ee_addr;
      ee_d <= ee_wdata;
    end
    if (pin_oe === 1'b1) oe_seen <= 1'b1;
    if (ee_rd_en === 1'b1) rd_seen <= 1'b1;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("timeout after %0d cycles", cycles);
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check_eq(input string what, input logic [15:0] seen,
                          input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_eq

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wait_fetch();
    for (int i = 0; i < 10 && fetch_valid !== 1'b1; i++) tick(1);
  endtask : wait_fetch

  task automatic tbl_read(input logic [1:0] kind, input logic [7:0] lo,
      input logic [7:0] hi, input logic [7:0] dest,
      input logic [15:0] word);
    tbl_kind = kind;
    tbl_ptr_low = lo;
    tbl_ptr_high = hi;
    tbl_dest = dest;
    tbl_req = 1'b1;
    tick(1);
    tbl_req = 1'b0;
    for (int i = 0; i < 2 && tbl_busy !== 1'b1; i++) tick(1);
    check_eq("tbl_busy", 16'(tbl_busy), 16'h0001);
    tick(1);
    check_eq("tbl_wr_en", 16'(tbl_wr_en), 16'h0001);
    check_eq("busy_end", 16'(tbl_busy), 16'h0000);
    check_eq("tbl_wr_addr", 16'(tbl_wr_addr), 16'(dest));
    check_eq("tbl_wr_data", 16'(tbl_wr_data), 16'(word[7:0]));
    check_eq("latch", 16'(latch), 16'(word[15:8]));
    tick(1);
  endtask : tbl_read

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_fetch();
    wait_fetch();
    check_eq("first_fetch", 16'(fetch_addr), 16'h0000);
    tick(1);
    check_eq("next_fetch", 16'(fetch_addr), 16'h0001);
    $display("done reset_fetch");
  endtask : t_reset_fetch

  task automatic t_program();
    prog.session(1'b1);
    check_eq("core_run_prog", 16'(core_run), 16'h0000);
    prog.frame(pmt_pkg::ICP_WR_PROG, 14'h0705, 16'h000F, rd);
    prog.frame(pmt_pkg::ICP_WR_PROG, 14'h0706, 16'h001A, rd);
    prog.frame(pmt_pkg::ICP_WR_PROG, 14'h0123, 16'hA55A, rd);
    prog.frame(pmt_pkg::ICP_WR_EE, 14'h0034, 16'h00C3, rd);
    check_eq("ee_addr", 16'(ee_a), 16'h0034);
    check_eq("ee_wdata", 16'(ee_d), 16'h00C3);
    prog.frame(pmt_pkg::ICP_RD_PROG, 14'h0706, 16'h0000, rd);
    check_eq("prog_rd", rd, 16'h001A);
    check_eq("oe_seen", 16'(oe_seen), 16'h0001);
    prog.frame(pmt_pkg::ICP_RD_EE, 14'h0034, 16'h0000, rd);
    check_eq("ee_rd", 16'(rd[7:0]), 16'h005A);
    check_eq("ee_rd_en", 16'(rd_seen), 16'h0001);
    prog.session(1'b0);
    wait_fetch();
    check_eq("restart", 16'(fetch_addr), 16'h0000);
    check_eq("core_run", 16'(core_run), 16'h0001);
    $display("done program");
  endtask : t_program

  task automatic t_table();
    tbl_read(2'h0, 8'h06, 8'h07, 8'h20, 16'h001A);
    tbl_read(2'h0, 8'h23, 8'h01, 8'h21, 16'hA55A);
    tbl_read(2'h2, 8'h05, 8'h00, 8'h22, 16'h000F);
    pc_load_addr = 11'h705;
    pc_load = 1'b1;
    tick(1);
    pc_load = 1'b0;
    check_eq("jump_valid", 16'(fetch_valid), 16'h0001);
    check_eq("jump_addr", 16'(fetch_addr), 16'h0705);
    check_eq("jump_word", fetch_word, 16'h000F);
    tick(1);
    check_eq("next_word", fetch_word, 16'h001A);
    pc_load_addr = 11'h1F0;
    pc_load = 1'b1;
    tick(1);
    pc_load = 1'b0;
    tick(2);
    tbl_read(2'h1, 8'h23, 8'h07, 8'h23, 16'hA55A);
    $display("done table");
  endtask : t_table

  task automatic t_latch_ro();
    tick(12);
    check_eq("latch_hold", 16'(latch), 16'h00A5);
    $display("done latch_ro");
  endtask : t_latch_ro

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    rst_n = 1'b0;
    pc_load = 1'b0;
    pc_load_addr = '0;
    tbl_req = 1'b0;
    tbl_kind = 2'h0;
    tbl_dest = 8'h00;
    tbl_ptr_low = 8'h00;
    tbl_ptr_high = 8'h00;
    ee_rdata = 8'h5A;
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset_fetch();
    t_program();
    t_table();
    t_latch_ro();
    complete_run();
  end
endmodule : program_memory_table_read_bench

`default_nettype wire
